// >>> dbg_attr_pkg.sv
// constants and types for the debug address-attribute match block
package dbg_attr_pkg;
  localparam logic [4:0]  DRC_TRIG_ATTR    = 5'h06;  // trigger attribute compare
  localparam logic [4:0]  DRC_TRIG_DEF     = 5'h07;  // trigger definition
  localparam logic [15:0] TRIG_ATTR_RESET  = 16'h0005;
  localparam logic [7:0]  PORT_ATTR_RESET  = 8'h05;
  localparam int          DIR_BIT          = 7;
  localparam int          SZ_LSB           = 5;
  localparam int          TK_LSB           = 3;
  localparam int          TM_LSB           = 0;
  localparam int          DIR_MASK_BIT     = 15;
  localparam int          SZ_MASK_LSB      = 13;
  localparam int          TK_MASK_LSB      = 11;
  localparam int          TM_MASK_LSB      = 8;
  localparam int          PROG_LOW_BITS    = 5;
  // size encodings
  localparam logic [1:0]  SIZE_LONG        = 2'h0;
  localparam logic [1:0]  SIZE_BYTE        = 2'h1;
  localparam logic [1:0]  SIZE_WORD        = 2'h2;
  // transfer kind encodings
  localparam logic [1:0]  TK_NORMAL        = 2'h0;
  localparam logic [1:0]  TK_EXT_DMA       = 2'h1;
  localparam logic [1:0]  TK_EMULATOR      = 2'h2;
  localparam logic [1:0]  TK_ACK_CPU       = 2'h3;
  // modifier encodings
  localparam logic [2:0]  TM_CPU_SPACE     = 3'h0;
  localparam logic [2:0]  TM_USER_DATA     = 3'h1;
  localparam logic [2:0]  TM_USER_CODE     = 3'h2;
  localparam logic [2:0]  TM_IACK_MAX      = 3'h4;

  typedef enum logic [1:0] {
    SPACE_NORMAL,
    SPACE_EXT_DMA,
    SPACE_EMULATOR,
    SPACE_ACK_CPU
  } space_kind_t;
endpackage

// >>> debug_address_attribute_match.sv
// debug address-attribute registers and local bus attribute comparator
// Functional notes
// - debug commands load direction and size; port loads low five
// - trigger attribute write also loads port attributes
// - port attributes reset to supervisor data 0x05
// - direction bit: 1 read, 0 write
// - size codes: long, byte, word, reserved
// - transfer kind codes: normal, emulator, acknowledge
// - kind 01 means external/DMA for commands
// - direction mask excludes direction from compare
// - size mask bits exclude size bits
// - kind mask bits exclude kind bits
// - modifier mask bits exclude modifier bits
// - compare against local bus attributes per definition
// - writable as debug control register 0x06
// - modifier meaning depends on transfer kind
// - trigger definition write clears trigger status
`timescale 1ns/10ps
module debug_address_attribute_match
  import dbg_attr_pkg::*;
(
  input  wire logic                  mclk_i,           // core clock
  input  wire logic                  reset_i,          // sync reset, active high
  input  wire logic                  ctl_wr_i,         // debug control register write strobe
  input  wire logic [4:0]            ctl_addr_i,       // debug control register number
  input  wire logic [31:0]           ctl_wdata_i,      // debug control write data
  input  wire logic                  cmd_mem_i,        // memory command issued on debug port
  input  wire logic                  cmd_read_i,       // command direction, 1 read
  input  wire logic [1:0]            cmd_size_i,       // command size code
  input  wire logic                  attr_wr_i,        // port write of low attribute bits
  input  wire logic [4:0]            attr_wdata_i,     // transfer kind and modifier
  input  wire logic                  bus_valid_i,      // local bus access in progress
  input  wire logic                  bus_read_i,       // local bus direction, 1 read
  input  wire logic [1:0]            bus_size_i,       // local bus size
  input  wire logic [1:0]            bus_kind_i,       // local bus transfer kind
  input  wire logic [2:0]            bus_mod_i,        // local bus transfer modifier
  output logic [7:0]                 port_attr_o,      // attributes for debug memory commands
  output dbg_attr_pkg::space_kind_t  port_space_o,     // decoded command space kind
  output logic                       port_attr_rsvd_o, // command attributes use reserved code
  output logic                       attr_match_o,     // qualified attribute match, registered
  output logic                       trig_status_clr_o // pulse: clear trigger status bits
);
  import dbg_attr_pkg::*;

  logic [15:0] trig_attr_r;
  logic [7:0]  port_attr_r;
  logic        match_r;
  logic        clr_r;
  logic        trig_attr_wr;
  logic [7:0]  bus_attr;
  logic [7:0]  care;

  // reserved combination check, applied only to the command attributes (port_attr_r)
  function automatic logic attr_reserved(input logic [7:0] a, input logic cmd);
    logic [1:0] sz;
    logic [1:0] tk;
    logic [2:0] tm;
    sz = a[SZ_LSB +: 2];
    tk = a[TK_LSB +: 2];
    tm = a[TM_LSB +: 3];
    attr_reserved = 1'b0;
    if (sz == 2'h3) begin
      attr_reserved = 1'b1;
    end
    // the modifier is only meaningful once the transfer kind is known
    case (tk)
      TK_NORMAL: begin
        if (tm != TM_USER_DATA && tm != TM_USER_CODE) begin
          attr_reserved = 1'b1;
        end
      end
      TK_EXT_DMA: begin
        // only commands may use this code; with cmd low it stays reserved
        if (!cmd) begin
          attr_reserved = 1'b1;
        end
      end
      TK_EMULATOR: begin
        attr_reserved = 1'b1;
      end
      default: begin
        if (tm > TM_IACK_MAX) begin
          attr_reserved = 1'b1;
        end
      end
    endcase
  endfunction

  assign trig_attr_wr = ctl_wr_i && (ctl_addr_i == DRC_TRIG_ATTR);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      trig_attr_r <= TRIG_ATTR_RESET;
    end else if (trig_attr_wr) begin
      trig_attr_r <= ctl_wdata_i[15:0];
    end
  end

  // a write of the trigger register wins over a same-cycle command load
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      port_attr_r <= PORT_ATTR_RESET;
    end else if (trig_attr_wr) begin
      port_attr_r <= ctl_wdata_i[7:0];
    end else begin
      if (cmd_mem_i) begin
        port_attr_r[DIR_BIT] <= cmd_read_i;
        port_attr_r[SZ_LSB +: 2] <= cmd_size_i;
      end
      if (attr_wr_i) begin
        port_attr_r[PROG_LOW_BITS-1:0] <= attr_wdata_i;
      end
    end
  end

  // mask bits set mean "don't care"
  assign care = ~{trig_attr_r[DIR_MASK_BIT],
                  trig_attr_r[SZ_MASK_LSB +: 2],
                  trig_attr_r[TK_MASK_LSB +: 2],
                  trig_attr_r[TM_MASK_LSB +: 3]};
  assign bus_attr = {bus_read_i, bus_size_i, bus_kind_i, bus_mod_i};

  // registered to keep the compare off the bus critical path; the
  // trigger definition logic consumes it one cycle after the access
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      match_r <= 1'b0;
    end else begin
      match_r <= bus_valid_i &&
                 (((bus_attr ^ trig_attr_r[7:0]) & care) == 8'h00);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      clr_r <= 1'b0;
    end else begin
      clr_r <= ctl_wr_i && (ctl_addr_i == DRC_TRIG_DEF);
    end
  end

  assign port_attr_o       = port_attr_r;
  assign port_space_o      = space_kind_t'(port_attr_r[TK_LSB +: 2]);
  assign port_attr_rsvd_o  = attr_reserved(port_attr_r, 1'b1);
  assign attr_match_o      = match_r;
  assign trig_status_clr_o = clr_r;
endmodule

// >>> dbg_attr_sva.sv
// assertions on the attribute match block ports
`timescale 1ns/10ps
module dbg_attr_sva(
  input wire logic mclk_i, reset_i, ctl_wr_i, cmd_mem_i, cmd_read_i, attr_wr_i,
  input wire logic [4:0] ctl_addr_i, attr_wdata_i,
  input wire logic [31:0] ctl_wdata_i,
  input wire logic [1:0] cmd_size_i, bus_size_i, bus_kind_i,
  input wire logic bus_valid_i, bus_read_i, port_attr_rsvd_o, attr_match_o, trig_status_clr_o,
  input wire logic [2:0] bus_mod_i,
  input wire logic [7:0] port_attr_o,
  input wire dbg_attr_pkg::space_kind_t port_space_o);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire w6 = ctl_wr_i && ctl_addr_i == 5'h06;
  wire w7 = ctl_wr_i && ctl_addr_i == 5'h07;
  a_reset_value: assert property ($past(reset_i) |-> port_attr_o == 8'h05)
    else $error("bad reset value");
  a_trig_load: assert property (w6 |=> port_attr_o == $past(ctl_wdata_i[7:0]))
    else $error("trigger write not copied");
  a_cmd_load: assert property (cmd_mem_i && !w6 |=>
    port_attr_o[7:5] == {$past(cmd_read_i), $past(cmd_size_i)}) else $error("cmd load");
  a_low_load: assert property (attr_wr_i && !w6 |=> port_attr_o[4:0] == $past(attr_wdata_i))
    else $error("low load");
  a_hold_attr: assert property (!ctl_wr_i && !cmd_mem_i && !attr_wr_i |=> $stable(port_attr_o))
    else $error("attr changed");
  a_clr_pulse: assert property (w7 |=> trig_status_clr_o) else $error("no clear");
  a_clr_cause: assert property (trig_status_clr_o |-> $past(w7)) else $error("stray clear");
  a_idle_nomatch: assert property (!bus_valid_i |=> !attr_match_o) else $error("idle match");
  a_space_decode: assert property (port_space_o == port_attr_o[4:3]) else $error("space");
  a_emul_rsvd: assert property (port_attr_o[4:3] == 2'h2 |-> port_attr_rsvd_o)
    else $error("emulator code not flagged");
  a_reset_quiet: assert property ($past(reset_i) |-> !attr_match_o && !trig_status_clr_o)
    else $error("outputs active after reset");
endmodule
bind debug_address_attribute_match dbg_attr_sva u_sva(.*);

// >>> local_bus_model.sv
// local bus model: sweeps all attribute patterns, idle one cycle in four
`timescale 1ns/10ps
module local_bus_model(
  input  wire logic       mclk_i,  // core clock
  output logic            valid_o, // access in progress
  output logic [7:0]      attr_o); // read, size, kind, modifier
  logic [9:0] cnt_r = 10'h000;
  // attributes hold for four cycles and step as the idle cycle ends, so each pattern is valid for three cycles
  always @(negedge mclk_i) cnt_r <= cnt_r + 10'h001;
  assign valid_o = cnt_r[1:0] != 2'h3;
  assign attr_o  = cnt_r[9:2];
endmodule

// >>> debug_address_attribute_match_test.sv
// testbench for the debug address-attribute block
`timescale 1ns/10ps
module debug_address_attribute_match_test;
  import dbg_attr_pkg::*;
  logic mclk_i = 0, reset_i = 1, ctl_wr_i = 0, cmd_mem_i = 0, cmd_read_i = 0, attr_wr_i = 0;
  logic [4:0] ctl_addr_i = 5'h00, attr_wdata_i = 5'h00;
  logic [31:0] ctl_wdata_i = 32'h0;
  logic [1:0] cmd_size_i = 2'h0;
  logic [7:0] port_attr_o;
  space_kind_t port_space_o;
  logic port_attr_rsvd_o, attr_match_o, trig_status_clr_o, bus_valid_i;
  wire [7:0] ba;
  wire bus_read_i = ba[7];
  wire [1:0] bus_size_i = ba[6:5], bus_kind_i = ba[4:3];
  wire [2:0] bus_mod_i = ba[2:0];
  logic [15:0] tv[5] = '{16'h0005, 16'h8096, 16'h60cb, 16'h1b39, 16'hff00};
  int n_errors = 0, samples_checked = 0;
  always #4 mclk_i = ~mclk_i;
  debug_address_attribute_match dut(.*);
  local_bus_model bus(.mclk_i(mclk_i), .valid_o(bus_valid_i), .attr_o(ba));
  task automatic chk(input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ctl(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    ctl_wr_i = 1; ctl_addr_i = a; ctl_wdata_i = {16'h0, d};
    @(negedge mclk_i) ctl_wr_i = 0;
  endtask
  task automatic t_match(input logic [15:0] t);
    logic e;
    ctl(DRC_TRIG_ATTR, t);
    chk(port_attr_o, t[7:0]);
    repeat (1024) begin
      @(posedge mclk_i) e = bus_valid_i && ((ba ^ t[7:0]) & ~t[15:8]) == 8'h00;
      @(negedge mclk_i) chk(attr_match_o, e);
    end
  endtask
  task automatic t_cmd;
    cmd_mem_i = 1; cmd_read_i = 1; cmd_size_i = SIZE_WORD; attr_wr_i = 1; attr_wdata_i = 5'h0b;
    @(negedge mclk_i) chk(port_attr_o, 8'hcb);
    chk(port_space_o, SPACE_EXT_DMA);
    chk(port_attr_rsvd_o, 1'b0);
    ctl(DRC_TRIG_ATTR, 16'h0012);
    chk(port_attr_o, 8'h12);
    chk(port_attr_rsvd_o, 1'b1);
    cmd_mem_i = 0; attr_wr_i = 0;
  endtask
  task automatic t_clr;
    ctl(DRC_TRIG_DEF, 16'hffff);
    chk(trig_status_clr_o, 1'b1);
    @(negedge mclk_i) chk(trig_status_clr_o, 1'b0);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge mclk_i);
    reset_i = 0;
    chk(port_attr_o, 8'h05);
    foreach (tv[i]) t_match(tv[i]);
    t_cmd;
    t_clr;
    reset_i = 1;
    @(negedge mclk_i) reset_i = 0;
    chk(port_attr_o, 8'h05);
    chk(attr_match_o, 1'b0);
    close_out;
  end
endmodule
